// ===== src/xtl_consts.svh
// Behaviour
// RL1 - Legacy direction-load opcode with selector 5..7 copies acc to direction register.
// RL2 - Direction registers are also plain file registers, readable and writable directly.
// RL3 - Literal XOR: acc xor 8-bit literal into acc, one cycle, zero flag only.
// RL4 - File XOR: acc xor file register at 7-bit address, one cycle, zero only.
// RL5 - Destination bit 0 writes acc, 1 writes the file register.
// RL6 - Zero flag set when XOR result is zero; carry and digit carry kept.
`ifndef XTL_CONSTS_SVH
`define XTL_CONSTS_SVH
// ****************************************
// Opcode fields
// ****************************************
`define XTL_OP_DIRLOAD   14'h0060
`define XTL_DIRLOAD_MASK 14'h3FF8
`define XTL_DIR_SEL_MIN  3'h5
`define XTL_DIR_SEL_MAX  3'h7
`define XTL_OP_XORLIT    6'h3A
`define XTL_OP_XORFILE   6'h06
`define XTL_DEST_BIT     7
`define XTL_ZERO_BIT     2
`define XTL_DIR_BASE     7'h05
`define XTL_ACC_RESET    8'h00
`define XTL_DIR_RESET    8'hFF
`define XTL_DIR_SPAN     7'h02
`define XTL_STATUS_RESET 8'h00
`define XTL_OPC_HI       13
`define XTL_OPC_LO       8
`define XTL_LIT_HI       7
`define XTL_FADDR_HI     6
`define XTL_SEL_HI       2
`define XTL_FIELD_LO     0
`endif

// ===== src/xtl_core.sv
`timescale 1ns/10ps
`include "xtl_consts.svh"
module xtl_core
    import xtl_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic        instr_valid,
    input  wire logic [13:0] instr,
    input  wire logic        acc_load,
    input  wire logic [7:0]  acc_load_data,
    input  wire logic        status_load,
    input  wire logic [7:0]  status_load_data,
    input  wire logic        file_we,
    input  wire logic [6:0]  file_addr,
    input  wire logic [7:0]  file_wdata,
    output logic      [7:0]  file_rdata,
    output logic      [7:0]  acc,
    output logic      [7:0]  status,
    output logic      [7:0]  dir_a,
    output logic      [7:0]  dir_b,
    output logic      [7:0]  dir_c,
    output logic             illegal
);
    // ****************************************
    // Declarations
    // ****************************************
    xtl_file_if fif ();
    xtl_op_t    op;
    logic [5:0] opc;
    logic [7:0] lit;
    logic [6:0] faddr;
    logic       dest_file;
    logic [2:0] sel;
    logic       sel_ok;
    logic [7:0] operand;
    logic [7:0] res;
    logic       res_zero;
    logic [7:0] acc_reg;
    logic [7:0] acc_next;
    logic [7:0] st_reg;
    logic [7:0] st_next;
    logic       ill_reg;
    logic       ill_next;
    // ****************************************
    // Instruction fields
    // ****************************************
    always_comb begin
        opc       = instr[`XTL_OPC_HI:`XTL_OPC_LO];
        lit       = instr[`XTL_LIT_HI:`XTL_FIELD_LO];
        faddr     = instr[`XTL_FADDR_HI:`XTL_FIELD_LO];
        dest_file = instr[`XTL_DEST_BIT];
        sel       = instr[`XTL_SEL_HI:`XTL_FIELD_LO];
        sel_ok    = (sel >= `XTL_DIR_SEL_MIN) && (sel <= `XTL_DIR_SEL_MAX);
    end
    // ****************************************
    // Decode
    // ****************************************
    always_comb begin
        op = XTL_OP_NONE;
        if (instr_valid) begin
            if ((instr & `XTL_DIRLOAD_MASK) == `XTL_OP_DIRLOAD) begin
                op = XTL_OP_DIR; // [RL1]
            end else if (opc == `XTL_OP_XORLIT) begin
                op = XTL_OP_XLIT; // [RL3]
            end else if (opc == `XTL_OP_XORFILE) begin
                op = XTL_OP_XFILE; // [RL4]
            end
        end
    end
    // ****************************************
    // File port address
    // ****************************************
    // The address is steered in a process of its own, so the read data that
    // feed the XOR never loop back into the process that picks the address.
    always_comb begin
        fif.addr = file_addr; // [RL2]
        case (op)
            XTL_OP_DIR: begin
                if (sel_ok) begin
                    fif.addr = 7'(sel); // [RL1]
                end
            end
            XTL_OP_XFILE: begin
                fif.addr = faddr; // [RL4]
            end
            default: begin
                fif.addr = file_addr;
            end
        endcase
    end
    // ****************************************
    // XOR datapath
    // ****************************************
    // One XOR serves both instructions; only the second operand differs.
    always_comb begin
        operand = lit;
        if (op == XTL_OP_XFILE) begin
            operand = fif.rdata; // [RL4]
        end
        res      = acc_reg ^ operand; // [RL3] [RL4]
        res_zero = (res == 8'h00); // [RL6]
    end
    // ****************************************
    // File write
    // ****************************************
    always_comb begin
        fif.wdata = file_wdata;
        fif.we    = file_we; // [RL2]
        case (op)
            XTL_OP_DIR: begin
                if (sel_ok) begin
                    fif.wdata = acc_reg;
                    fif.we    = 1'b1; // [RL1]
                end
            end
            XTL_OP_XFILE: begin
                fif.wdata = res;
                fif.we    = dest_file; // [RL5]
            end
            default: begin
                fif.wdata = file_wdata;
                fif.we    = file_we;
            end
        endcase
    end
    // ****************************************
    // Working register
    // ****************************************
    // Plain loads apply only when no decoded instruction claims the cycle,
    // so a stray load can never override a result.
    always_comb begin
        acc_next = acc_reg;
        case (op)
            XTL_OP_XLIT: begin
                acc_next = res; // [RL3]
            end
            XTL_OP_XFILE: begin
                if (!dest_file) begin
                    acc_next = res; // [RL5]
                end
            end
            XTL_OP_NONE: begin
                if (acc_load) begin
                    acc_next = acc_load_data;
                end
            end
            default: begin
                acc_next = acc_reg;
            end
        endcase
    end
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            acc_reg <= `XTL_ACC_RESET;
        end else begin
            acc_reg <= acc_next;
        end
    end
    // ****************************************
    // Status
    // ****************************************
    // Only the zero flag is written by an XOR, so carry and digit carry keep
    // whatever an earlier instruction left in them.
    always_comb begin
        st_next = st_reg;
        case (op)
            XTL_OP_XLIT, XTL_OP_XFILE: begin
                st_next[`XTL_ZERO_BIT] = res_zero; // [RL6]
            end
            XTL_OP_NONE: begin
                if (status_load) begin
                    st_next = status_load_data;
                end
            end
            default: begin
                st_next = st_reg; // [RL1]
            end
        endcase
    end
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st_reg <= `XTL_STATUS_RESET;
        end else begin
            st_reg <= st_next;
        end
    end
    // ****************************************
    // Refused selector
    // ****************************************
    // A selector below the lowest direction register writes nothing and is
    // flagged for one cycle.
    always_comb begin
        ill_next = (op == XTL_OP_DIR) && !sel_ok; // [RL1]
    end
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ill_reg <= 1'b0;
        end else begin
            ill_reg <= ill_next;
        end
    end
    // ****************************************
    // File storage
    // ****************************************
    xtl_file_mem u_mem (
        .clk_sys (clk_sys),
        .rst     (rst),
        .fif     (fif.mem),
        .dir_a   (dir_a),
        .dir_b   (dir_b),
        .dir_c   (dir_c)
    );
    // ****************************************
    // Outputs
    // ****************************************
    assign file_rdata = fif.rdata;
    assign acc        = acc_reg;
    assign status     = st_reg;
    assign illegal    = ill_reg;
endmodule : xtl_core

// ===== src/xtl_file_if.sv
`timescale 1ns/10ps
interface xtl_file_if;
    logic [6:0] addr;
    logic [7:0] wdata;
    logic       we;
    logic [7:0] rdata;
    modport core (output addr, output wdata, output we, input rdata);
    modport mem  (input addr, input wdata, input we, output rdata);
endinterface : xtl_file_if

// ===== src/xtl_file_mem.sv
`timescale 1ns/10ps
`include "xtl_consts.svh"
module xtl_file_mem (
    input wire logic clk_sys,
    input wire logic rst,
    xtl_file_if.mem  fif,
    output logic [7:0] dir_a,
    output logic [7:0] dir_b,
    output logic [7:0] dir_c
);
    // ****************************************
    // Storage
    // ****************************************
    // Reads are combinational so the one-cycle XOR sees the current value.
    logic [7:0] mem_reg [0:127];
    logic [7:0] dir_reg [0:2];
    logic [1:0] didx;
    logic       is_dir;
    always_comb begin
        didx   = 2'(fif.addr - `XTL_DIR_BASE);
        is_dir = (fif.addr >= `XTL_DIR_BASE) && (fif.addr <= (`XTL_DIR_BASE + `XTL_DIR_SPAN));
        fif.rdata = is_dir ? dir_reg[didx] : mem_reg[fif.addr]; // [RL2]
    end
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            dir_reg[0] <= `XTL_DIR_RESET;
            dir_reg[1] <= `XTL_DIR_RESET;
            dir_reg[2] <= `XTL_DIR_RESET;
        end else if (fif.we && is_dir) begin
            dir_reg[didx] <= fif.wdata; // [RL1] [RL2]
        end
    end
    always_ff @(posedge clk_sys) begin
        if (fif.we && !is_dir) begin
            mem_reg[fif.addr] <= fif.wdata;
        end
    end
    assign dir_a = dir_reg[0];
    assign dir_b = dir_reg[1];
    assign dir_c = dir_reg[2];
endmodule : xtl_file_mem

// ===== src/xtl_pkg.sv
package xtl_pkg;
    typedef enum logic [1:0] {
        XTL_OP_NONE,
        XTL_OP_DIR,
        XTL_OP_XLIT,
        XTL_OP_XFILE
    } xtl_op_t;
endpackage : xtl_pkg

// ===== verification/xtl_core_chk.sv
`timescale 1ns/10ps
module xtl_chk (
    input wire logic        clk_sys,
    input wire logic        rst,
    input wire logic        instr_valid,
    input wire logic [13:0] instr,
    input wire logic [7:0]  file_rdata,
    input wire logic [7:0]  acc,
    input wire logic [7:0]  status,
    input wire logic [7:0]  dir_a,
    input wire logic        illegal
);
    // ****************************************
    // Decode watchers
    // ****************************************
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    wire logic xl = instr_valid && instr[13:8] == 6'h3A;
    wire logic xf = instr_valid && instr[13:8] == 6'h06;
    wire logic dl = instr_valid && instr[13:3] == 11'h00C;
    sequence s_to_acc;
        xl || (xf && !instr[7]);
    endsequence
    a_xlit_acc: assert property (xl |=> acc == ($past(acc) ^ $past(instr[7:0])))
        else $error("literal xor result wrong");
    a_xfile_acc: assert property (xf && !instr[7] |=> acc == $past(acc ^ file_rdata))
        else $error("file xor result wrong");
    a_xfile_dest: assert property (xf && instr[7] |=> $stable(acc))
        else $error("file xor disturbed acc");
    a_zero_flag: assert property (s_to_acc |=> status[2] == (acc == 8'h00))
        else $error("zero flag wrong");
    a_carry_kept: assert property ((xl || xf) |=> $stable(status[1:0]))
        else $error("carry flags changed");
    a_dir_load: assert property (dl && instr[2:0] == 3'h5 |=>
        dir_a == $past(acc) && $stable(status))
        else $error("direction load wrong");
    a_bad_sel: assert property (dl && instr[2:0] < 3'h5 |=> illegal && $stable(dir_a))
        else $error("refused selector not flagged");
endmodule : xtl_chk
bind xtl_core xtl_chk u_chk (.clk_sys(clk_sys), .rst(rst), .instr_valid(instr_valid),
    .instr(instr), .file_rdata(file_rdata), .acc(acc), .status(status), .dir_a(dir_a),
    .illegal(illegal));

// ===== verification/xtl_core_tb_top.sv
`timescale 1ns/10ps
module xtl_core_tb_top;
    logic        clk_sys, rst, instr_valid, acc_load, status_load, file_we, illegal;
    logic [13:0] instr;
    logic [6:0]  file_addr;
    logic [7:0]  acc_load_data, status_load_data, file_wdata, file_rdata, acc, status;
    logic [7:0]  dir_a, dir_b, dir_c;
    int          fails = 0;
    int          compares = 0;
    xtl_core dut (.clk_sys(clk_sys), .rst(rst), .instr_valid(instr_valid), .instr(instr),
        .acc_load(acc_load), .acc_load_data(acc_load_data), .status_load(status_load),
        .status_load_data(status_load_data), .file_we(file_we), .file_addr(file_addr),
        .file_wdata(file_wdata), .file_rdata(file_rdata), .acc(acc), .status(status),
        .dir_a(dir_a), .dir_b(dir_b), .dir_c(dir_c), .illegal(illegal));
    // ****************************************
    // Helpers
    // ****************************************
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    // Strobes drop one step after the edge and a quiet cycle follows, so each
    // request is seen once and no strobe is dropped and raised in one step.
    task automatic tick;
        @(posedge clk_sys);
        #1;
        {instr_valid, acc_load, status_load, file_we} = 4'h0;
        @(posedge clk_sys);
        #1;
    endtask : tick
    task automatic op(input logic [13:0] w);
        instr_valid = 1'b1;
        instr = w;
        tick();
    endtask : op
    task automatic setup(input logic [7:0] a, input logic [7:0] s);
        {acc_load, status_load} = 2'h3;
        {acc_load_data, status_load_data} = {a, s};
        tick();
    endtask : setup
    task automatic fw(input logic [6:0] a, input logic [7:0] d);
        file_we = 1'b1;
        {file_addr, file_wdata} = {a, d};
        tick();
    endtask : fw
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_literal;
        setup(8'hB5, 8'h03);
        op(14'h3AAF);
        chk("acc", 8'h1A, acc);
        chk("status", 8'h03, status);
        op(14'h3A1A);
        chk("acc", 8'h00, acc);
        chk("status", 8'h07, status);
    endtask : t_literal
    task automatic t_file;
        fw(7'h7F, 8'hAF);
        setup(8'hB5, 8'h04);
        op(14'h06FF);
        chk("acc", 8'hB5, acc);
        chk("file", 8'h1A, file_rdata);
        chk("status", 8'h00, status);
        op(14'h067F);
        chk("acc", 8'hAF, acc);
        chk("file", 8'h1A, file_rdata);
    endtask : t_file
    task automatic t_dir;
        for (int i = 5; i < 8; i++) begin
            setup(8'(i * 17), 8'h05);
            op(14'h0060 + 14'(i));
        end
        chk("dir_a", 8'h55, dir_a);
        chk("dir_b", 8'h66, dir_b);
        chk("dir_c", 8'h77, dir_c);
        chk("status", 8'h05, status);
        fw(7'h06, 8'hC3);
        chk("dir_b", 8'hC3, dir_b);
        chk("file", 8'hC3, file_rdata);
    endtask : t_dir
    task automatic t_refuse;
        setup(8'h3C, 8'h05);
        {instr_valid, instr} = {1'b1, 14'h0063};
        {acc_load, acc_load_data} = {1'b1, 8'hE1};
        @(posedge clk_sys);
        #1;
        {instr_valid, acc_load} = 2'h0;
        chk("illegal", 8'h01, 8'(illegal));
        chk("acc", 8'h3C, acc);
        @(posedge clk_sys);
        #1;
        chk("illegal", 8'h00, 8'(illegal));
        chk("dir_a", 8'h55, dir_a);
    endtask : t_refuse
    task automatic report_and_stop;
        $display("Comparisons %0d, mismatches %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : report_and_stop
    initial begin
        {rst, instr_valid, acc_load, status_load, file_we} = 5'h10;
        {instr, file_addr, acc_load_data, status_load_data, file_wdata} = '0;
        repeat (3) @(posedge clk_sys);
        #1;
        rst = 1'b0;
        chk("dir_a", 8'hFF, dir_a);
        t_literal();
        t_file();
        t_dir();
        t_refuse();
        report_and_stop();
    end
endmodule : xtl_core_tb_top
